/* inc/hsc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define HSC_ADDR_CFG 8'h00
`define HSC_ADDR_SETP 8'h04
`define HSC_ADDR_STAT 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HSC_F_SEAL 0
`define HSC_F_COOL 8
`define HSC_F_THR 16
`define HSC_F_AT_SP 24
`define HSC_F_COOL_TMP 25
`define HSC_F_HZ60 26
`define HSC_F_RLY_COOL 27
`define HSC_F_SP 0
`define HSC_F_TOP 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HSC_CFG_RST 32'h0000_0000
`define HSC_SETP_RST 32'h012C_0096

// ----------------------------------------
// Timing
// ----------------------------------------
`define HSC_MAX_TENTHS 7'h63
`define HSC_TENTH_US 100000
`define HSC_PER50_US 20000
`define HSC_PER60_US 16667
`define HSC_CYC50 ((`HSC_TENTH_US + `HSC_PER50_US / 2) / `HSC_PER50_US)
`define HSC_CYC60 ((`HSC_TENTH_US + `HSC_PER60_US / 2) / `HSC_PER60_US)
`define HSC_MON_DIV 10
`define HSC_BLINK_CYC 25
`define HSC_NEAR_C 11'h00A
`define HSC_OVH_NUM 13'h0006
`define HSC_OVH_DEN 13'h0005
`define HSC_THR_STEP 10'h00A

`endif

/* inc/hsc_pkg.sv */
// Types of the heat-seal cycle sequencer
package hsc_pkg;

    typedef enum logic [1:0] {
        HSC_MON,
        HSC_HWAIT,
        HSC_SEAL,
        HSC_COOL
    } hsc_state_e;

    typedef struct packed {
        logic [13:0] sync1;
        logic [13:0] sync2;
        logic zc_d;
        hsc_state_e state;
        logic [2:0] sub;
        logic [6:0] tenths;
        logic [3:0] mon_cnt;
        logic [4:0] blink_cnt;
        logic blink;
        logic alarm;
        logic led_on;
        logic led_heat;
        logic led_cool;
        logic out_relay;
        logic heat_en;
        logic drv_full;
        logic meas;
        logic [31:0] cfg;
        logic [31:0] setp;
        logic a_wr;
        logic [7:0] a_addr;
        logic [31:0] rdata;
        logic ready;
    } hsc_st_s;

endpackage

/* verilog/hsc_cycle_seq.sv */
// Heat-seal cycle sequencer with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "hsc_cfg.svh"

module hsc_cycle_seq #(
    parameter bit ALARM_EN = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [9:0] temp_c,
    input wire logic start_hand,
    input wire logic start_contact,
    input wire logic start_24v,
    input wire logic reset_btn,
    input wire logic line_zc,
    input wire logic calib_low,
    input wire logic fault_open,
    input wire logic fault_band,
    input wire logic fault_short,
    input wire logic fault_wiring,
    input wire logic fault_secondary_voltage_select,
    input wire logic fault_freq_jumper,
    input wire logic fault_supply,
    input wire logic fault_internal,
    output logic led_power_on,
    output logic led_heat,
    output logic led_cool,
    output logic led_relay,
    output logic led_alarm,
    output logic alarm_relay,
    output logic output_relay,
    output logic heat_enable,
    output logic drive_full,
    output logic meas_pulse
);
    import hsc_pkg::*;

    hsc_st_s s;
    hsc_st_s n;
    logic [13:0] pins;
    logic tick;
    logic start_any;
    logic start_ok;
    logic armed;
    logic ovh;
    logic fault;
    logic seal_done;
    logic cool_done;
    logic below_thr;
    logic regul;
    logic [2:0] per;
    logic [6:0] seal_t;
    logic [6:0] cool_t;
    logic [9:0] thr_c;
    logic [9:0] sp_c;
    logic [9:0] top_c;
    logic a_take;

    // ----------------------------------------
    // Pins into the clock domain
    // ----------------------------------------
    assign pins = {fault_internal, fault_supply, fault_freq_jumper,
                   fault_secondary_voltage_select, fault_wiring, fault_short,
                   fault_band, fault_open, calib_low, line_zc, reset_btn,
                   start_24v, start_contact, start_hand};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = s;
        n.sync1 = pins;
        n.sync2 = s.sync1;
        n.zc_d = s.sync2[4];
        n.meas = 1'b0;
        tick = s.sync2[4] & ~s.zc_d;
        // Power is assumed up before any start level appears
        start_any = |s.sync2[2:0];
        sp_c = s.setp[`HSC_F_SP +: 10];
        top_c = s.setp[`HSC_F_TOP +: 10];
        // Selector values above 99 are clipped to 9.9s
        seal_t = (s.cfg[`HSC_F_SEAL +: 7] > `HSC_MAX_TENTHS) ?
                 `HSC_MAX_TENTHS : s.cfg[`HSC_F_SEAL +: 7];
        cool_t = (s.cfg[`HSC_F_COOL +: 7] > `HSC_MAX_TENTHS) ?
                 `HSC_MAX_TENTHS : s.cfg[`HSC_F_COOL +: 7];
        thr_c = {3'b000, s.cfg[`HSC_F_THR +: 7]} * `HSC_THR_STEP;
        below_thr = temp_c < thr_c;
        per = s.cfg[`HSC_F_HZ60] ? 3'(`HSC_CYC60) : 3'(`HSC_CYC50);
        armed = s.state != HSC_MON;
        ovh = ({3'b000, temp_c} * `HSC_OVH_DEN) >=
              ({3'b000, top_c} * `HSC_OVH_NUM);
        fault = ALARM_EN & ((|s.sync2[13:6])
                | (armed & ovh)
                | ((s.state == HSC_MON) & start_any & s.sync2[5]));
        // Without alarm capability a miscalibrated start is simply dropped
        start_ok = (s.state == HSC_MON) & start_any & ~s.alarm
                   & ~s.sync2[5] & ~fault;
        seal_done = s.tenths >= seal_t;
        cool_done = (s.tenths >= cool_t)
                    | (s.cfg[`HSC_F_COOL_TMP] & below_thr);

        // Latched alarm; a new fault beats the reset button
        n.alarm = fault | (s.alarm & ~s.sync2[3]);

        // Tenth-second timebase on line cycles
        if (tick) begin
            if (s.sub == per - 3'h1) begin
                n.sub = 3'h0;
                n.tenths = s.tenths + 7'h01;
            end else begin
                n.sub = s.sub + 3'h1;
            end
        end

        case (s.state)
            HSC_MON: begin
                if (start_ok) begin
                    n.sub = 3'h0;
                    n.tenths = 7'h00;
                    n.state = s.cfg[`HSC_F_AT_SP] ? HSC_HWAIT : HSC_SEAL;
                end
            end
            HSC_HWAIT: begin
                if (temp_c >= sp_c) begin
                    n.sub = 3'h0;
                    n.tenths = 7'h00;
                    n.state = HSC_SEAL;
                end
            end
            HSC_SEAL: begin
                if (seal_done) begin
                    n.sub = 3'h0;
                    n.tenths = 7'h00;
                    n.state = HSC_COOL;
                end
            end
            HSC_COOL: begin
                if (cool_done) begin
                    n.state = HSC_MON;
                end
            end
            default: begin
                n.state = HSC_MON;
            end
        endcase
        // Shutdown on alarm cuts a sequence short from any state; with the cool-by-temperature bit set, cool also ends early below threshold
        if (n.alarm) begin
            n.state = HSC_MON;
        end

        regul = (n.state == HSC_HWAIT) | (n.state == HSC_SEAL);

        // Sampling: every cycle when regulating, else every tenth
        if (tick) begin
            if (regul) begin
                n.meas = 1'b1;
                n.mon_cnt = 4'h0;
            end else if (s.mon_cnt == 4'(`HSC_MON_DIV - 1)) begin
                n.meas = 1'b1;
                n.mon_cnt = 4'h0;
            end else begin
                n.mon_cnt = s.mon_cnt + 4'h1;
            end
            if (s.blink_cnt == 5'(`HSC_BLINK_CYC - 1)) begin
                n.blink_cnt = 5'h00;
                n.blink = ~s.blink;
            end else begin
                n.blink_cnt = s.blink_cnt + 5'h01;
            end
        end

        n.led_on = regul | s.blink;
        n.led_heat = n.state == HSC_SEAL;
        n.led_cool = n.state == HSC_COOL;
        n.heat_en = regul & ~n.alarm;
        n.drv_full = n.heat_en
                     & (({1'b0, temp_c} + `HSC_NEAR_C) < {1'b0, sp_c});
        n.out_relay = ~n.alarm & (regul | ((n.state == HSC_COOL)
                      & s.cfg[`HSC_F_RLY_COOL]));

        // ----------------------------------------
        // AHB-Lite slave, zero wait states
        // ----------------------------------------
        n.ready = 1'b1;
        if (s.a_wr) begin
            case (s.a_addr)
                `HSC_ADDR_CFG: n.cfg = hwdata;
                `HSC_ADDR_SETP: n.setp = hwdata;
                default: n.cfg = s.cfg;
            endcase
        end
        a_take = hsel & htrans[1] & hready;
        n.a_wr = a_take & hwrite & (hsize == 3'b010);
        n.a_addr = haddr[7:0];
        if (a_take & ~hwrite) begin
            case (haddr[7:0])
                `HSC_ADDR_CFG: n.rdata = s.cfg;
                `HSC_ADDR_SETP: n.rdata = s.setp;
                `HSC_ADDR_STAT: n.rdata = {16'h0000, 1'b0, s.tenths, 1'b0,
                    s.alarm, s.out_relay, s.heat_en, s.led_cool, s.led_heat,
                    s.led_on, s.drv_full};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.cfg <= `HSC_CFG_RST;
            s.setp <= `HSC_SETP_RST;
            s.ready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hreadyout = s.ready;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign led_power_on = s.led_on;
    assign led_heat = s.led_heat;
    assign led_cool = s.led_cool;
    assign led_relay = s.out_relay;
    assign led_alarm = s.alarm;
    assign alarm_relay = s.alarm;
    assign output_relay = s.out_relay;
    assign heat_enable = s.heat_en;
    assign drive_full = s.drv_full;
    assign meas_pulse = s.meas;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence seq_start;
        (s.state == HSC_MON) && start_ok;
    endsequence

    sequence seq_seal_end;
        (s.state == HSC_SEAL) && seal_done && !fault;
    endsequence

    a_mon_no_heat: assert property ((s.state == HSC_MON) |-> !s.heat_en && !s.drv_full)
        else $error("heat drive while monitoring");
    a_led_steady: assert property ((s.state == HSC_SEAL) |-> s.led_on[*1] ##0 s.led_heat)
        else $error("power LED not steady in seal");
    a_full_near: assert property (s.drv_full |-> ($past(temp_c) + 10'd10) < $past(sp_c))
        else $error("full drive near setpoint");
    a_start_launch: assert property (seq_start |=> (s.state != HSC_MON) && s.out_relay)
        else $error("start not launched");
    a_seal_cool: assert property (seq_seal_end |=> (s.state == HSC_COOL) && s.led_cool && !s.led_heat)
        else $error("cool not right after seal");
    a_time_cap: assert property ((s.state == HSC_SEAL) |-> s.tenths <= 7'd99)
        else $error("seal time beyond cap");
    a_cool_temp: assert property ((s.state == HSC_COOL) && s.cfg[`HSC_F_COOL_TMP]
        && below_thr && !fault |=> (s.state == HSC_MON) && !s.out_relay)
        else $error("cool not ended at threshold");
    a_alarm_off: assert property (s.alarm |-> !s.heat_en && !s.out_relay && alarm_relay)
        else $error("output live in alarm");
    a_alarm_hold: assert property (s.alarm && !s.sync2[3] |=> s.alarm)
        else $error("alarm dropped without reset");
    a_meas_regul: assert property (tick && regul |=> s.meas)
        else $error("no sample on line cycle while regulating");
    a_hwait_hold: assert property ((s.state == HSC_HWAIT) && (temp_c < sp_c) && !fault |=> (s.state == HSC_HWAIT))
        else $error("seal timer started below setpoint");
endmodule
`default_nettype wire

/* tb/hsc_partner.sv */
// Model of the machine start sources, line supply and heating element power stage
`timescale 1ns/1ns
`default_nettype none

module hsc_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] start_req,
    input wire logic runaway,
    input wire logic heat_enable,
    output logic line_zc,
    output logic start_hand,
    output logic start_contact,
    output logic start_24v,
    output logic [9:0] temp_c
);
    logic powered;

    // ----------------------------------------
    // Line supply runs free, unrelated to hclk
    // ----------------------------------------
    initial begin
        line_zc = 1'b0;
        forever #410 line_zc = ~line_zc;
    end

    // ----------------------------------------
    // Starts
    // ----------------------------------------
    // Starts held low until one edge after power is up, never together with it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            powered <= 1'b0;
        end else begin
            powered <= 1'b1;
        end
    end
    assign start_hand = powered & start_req[0];
    assign start_contact = powered & start_req[1];
    assign start_24v = powered & start_req[2];

    // ----------------------------------------
    // Element temperature
    // ----------------------------------------
    // Clamped at 150 degC unless runaway, which stands for a failed regulator
    // One process owns the temperature, so it has a single driver
    initial begin
        temp_c = 10'h014;
        forever begin
            @(posedge line_zc);
            if (heat_enable && (runaway || temp_c < 10'h096)) begin
                temp_c <= temp_c + 10'h005;
            end else if (!heat_enable && temp_c > 10'h014) begin
                temp_c <= temp_c - 10'h005;
            end
        end
    end
endmodule

`default_nettype wire

/* tb/hsc_cycle_seq_bench.sv */
// Self-checking bench of the heat-seal cycle sequencer
`timescale 1ns/1ns
`default_nettype none

module hsc_cycle_seq_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0] fault = 8'h00;
    logic [2:0] start_req = 3'b000;
    logic reset_btn = 1'b0;
    logic calib_low = 1'b0;
    logic runaway = 1'b0;
    logic rd_dp = 1'b0;
    wire logic hreadyout, hresp, line_zc, start_hand, start_contact, start_24v, led_power_on, led_heat;
    wire logic led_cool, led_relay, led_alarm, alarm_relay, output_relay, heat_enable, drive_full, meas_pulse;
    wire logic [31:0] hrdata;
    wire logic [9:0] temp_c;
    wire logic [3:0] obs;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] q_rd[$];
    int q_seal[$];
    int q_cool[$];
    int n_heat, n_cool, n_meas, k, n;
    logic zc_p, heat_p, cool_p;
    logic zc_m, on_m;
    int nb;
    logic [31:0] cfg;

    assign obs = {led_alarm, led_cool, led_heat, heat_enable};

    hsc_cycle_seq uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .temp_c(temp_c), .start_hand(start_hand),
        .start_contact(start_contact), .start_24v(start_24v), .reset_btn(reset_btn), .line_zc(line_zc),
        .calib_low(calib_low), .fault_open(fault[0]), .fault_band(fault[1]), .fault_short(fault[2]),
        .fault_wiring(fault[3]), .fault_secondary_voltage_select(fault[4]), .fault_freq_jumper(fault[5]),
        .fault_supply(fault[6]), .fault_internal(fault[7]), .led_power_on(led_power_on), .led_heat(led_heat),
        .led_cool(led_cool), .led_relay(led_relay), .led_alarm(led_alarm), .alarm_relay(alarm_relay),
        .output_relay(output_relay), .heat_enable(heat_enable), .drive_full(drive_full), .meas_pulse(meas_pulse));

    hsc_partner far_side (.hclk(hclk), .hresetn(hresetn), .start_req(start_req), .runaway(runaway),
        .heat_enable(heat_enable), .line_zc(line_zc), .start_hand(start_hand), .start_contact(start_contact),
        .start_24v(start_24v), .temp_c(temp_c));

    initial begin
        forever #20 hclk = ~hclk;
    end

    // ----------------------------------------
    // Compare, wait and bus tasks
    // ----------------------------------------
    task automatic report_and_stop;
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Line-cycle counts carry a little slack for the unknown zero-cross phase
    task automatic chk_win(input string nm, input int e, input int g);
        comparisons++;
        if (g < e - 2 || g > e + 2) begin
            err_total++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge hclk);
    endtask

    // Polls on the falling edge so outputs are settled when looked at
    task automatic wait_obs(input int b, input logic lvl);
        int w;
        w = 0;
        while (obs[b] !== lvl) begin
            @(negedge hclk);
            w++;
            if (w > 30000) begin
                err_total++;
                report_and_stop();
            end
        end
    endtask

    task automatic hold;
        int w;
        w = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            w++;
            if (w > 100) begin
                err_total++;
                report_and_stop();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        hold();
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp <= !wr;
        if (!wr) begin
            q_rd.push_back(e);
        end
        hold();
        rd_dp <= 1'b0;
    endtask

    task automatic clear_alarm;
        reset_btn <= 1'b1;
        cyc(4);
        reset_btn <= 1'b0;
        wait_obs(3, 1'b0);
        cyc(1);
    endtask

    task automatic run_seq(input int src, input logic [31:0] c, input int se, input int ce);
        bus(1'b1, 8'h00, c, 32'h0000_0000);
        q_seal.push_back(se);
        q_cool.push_back(ce);
        start_req <= 3'b001 << src;
        wait_obs(0, 1'b1);
        cyc(2);
        @(negedge hclk);
        chk("heat led at start", {31'h0, !c[24]}, led_heat);
        chk("full drive", 32'h0000_0001, drive_full);
        chk("steady power led", 32'h0000_0001, led_power_on);
        cyc(1);
        start_req <= 3'b000;
        wait_obs(1, 1'b1);
        cyc(20);
        start_req <= 3'b111;
        cyc(20);
        start_req <= 3'b000;
        wait_obs(2, 1'b1);
        wait_obs(2, 1'b0);
        chk("relay after cool", 32'h0000_0000, output_relay);
        cyc(4);
    endtask

    // ----------------------------------------
    // Watchers: each result takes the oldest note
    // ----------------------------------------
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            chk("hrdata", q_rd.pop_front(), hrdata);
            chk("hresp", 32'h0000_0000, hresp);
        end
    end

    always @(negedge hclk) begin
        chk("relay led", output_relay, led_relay);
        if (led_alarm === 1'b1) begin
            chk("alarm outputs", 32'h0000_0002, {alarm_relay, heat_enable});
        end
        if (led_heat === 1'b1) begin
            chk("power led in seal", 32'h0000_0001, led_power_on);
            n_meas += meas_pulse;
        end
        if (line_zc && !zc_p) begin
            n_heat += led_heat;
            n_cool += led_cool;
        end
        if (heat_p && !led_heat && !led_alarm) begin
            chk_win("seal length", q_seal.pop_front(), n_heat);
            chk_win("samples in seal", n_heat, n_meas);
            chk("cool follows seal", 32'h0000_0001, led_cool);
        end
        if (cool_p && !led_cool && !led_alarm) begin
            chk_win("cool length", q_cool.pop_front(), n_cool);
        end
        if (!heat_p && led_heat) begin
            n_heat = 0;
            n_meas = 0;
        end
        if (!cool_p && led_cool) begin
            n_cool = 0;
        end
        zc_p = line_zc;
        heat_p = led_heat;
        cool_p = led_cool;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        k = $urandom(32'hed201100);
        cyc(4);
        hresetn <= 1'b1;
        cyc(2);
        bus(1'b0, 8'h00, 32'h0000_0000, 32'h0000_0000);
        bus(1'b0, 8'h04, 32'h0000_0000, 32'h012C_0096);
        bus(1'b1, 8'h0C, $urandom(), 32'h0000_0000);
        bus(1'b0, 8'h0C, 32'h0000_0000, 32'h0000_0000);
        cfg = {9'h000, 7'($urandom_range(99)), 1'b0, 7'($urandom_range(99)), 1'b0, 7'($urandom_range(99))};
        bus(1'b1, 8'h00, cfg, 32'h0000_0000);
        bus(1'b0, 8'h00, 32'h0000_0000, cfg);
        n = 0;
        k = 0;
        nb = 0;
        zc_m = line_zc;
        on_m = led_power_on;
        // Own edge memory: the watcher's copy is updated in the same time step
        for (int w = 0; w < 30000 && k < 50; w++) begin
            @(negedge hclk);
            n += meas_pulse;
            k += (line_zc && !zc_m) ? 1 : 0;
            nb += (led_power_on !== on_m) ? 1 : 0;
            zc_m = line_zc;
            on_m = led_power_on;
        end
        if (k < 50) begin
            err_total++;
            report_and_stop();
        end
        chk_win("idle samples", 5, n);
        chk("power led blinks", 32'h0000_0001, nb >= 1);
        chk("no heat when idle", 32'h0000_0000, heat_enable);
        cyc(1);
        for (int src = 0; src < 3; src++) begin
            n = $urandom_range(4, 1);
            k = $urandom_range(3, 1);
            cfg = {5'h00, (src == 2), 10'h000, 1'b0, 7'(k), 1'b0, 7'(n)};
            run_seq(src, cfg, n * ((src == 2) ? 6 : 5), k * ((src == 2) ? 6 : 5));
        end
        run_seq(0, 32'h0B08_6302, 10, 15);
        run_seq(1, 32'h0000_007F, 495, 0);
        for (int i = 0; i < 8; i++) begin
            fault <= 8'h01 << i;
            wait_obs(3, 1'b1);
            cyc(1);
            fault <= 8'h00;
            cyc(5);
            @(negedge hclk);
            chk("alarm held", 32'h0000_0001, led_alarm);
            cyc(1);
            if (i == 7) begin
                hresetn <= 1'b0;
                cyc(2);
                hresetn <= 1'b1;
                wait_obs(3, 1'b0);
                cyc(1);
            end else begin
                clear_alarm();
            end
        end
        calib_low <= 1'b1;
        cyc(40);
        @(negedge hclk);
        chk("no alarm while idle", 32'h0000_0000, led_alarm);
        cyc(1);
        start_req <= 3'b010;
        wait_obs(3, 1'b1);
        chk("no heat on bad zero", 32'h0000_0000, heat_enable);
        cyc(1);
        start_req <= 3'b000;
        calib_low <= 1'b0;
        clear_alarm();
        bus(1'b1, 8'h00, 32'h0000_0063, 32'h0000_0000);
        runaway <= 1'b1;
        start_req <= 3'b100;
        wait_obs(3, 1'b1);
        chk("overheat point", 32'h0000_0001, (temp_c >= 10'h168) && (temp_c <= 10'h16D));
        cyc(1);
        start_req <= 3'b000;
        runaway <= 1'b0;
        clear_alarm();
        report_and_stop();
    end
endmodule

`default_nettype wire
